/* File: rtl/dbrk_top.sv */
// Breakpoint control of the serial debug port, link write side included.
`include "dbrk_regs.svh"
module dbrk_top (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic LINK_CLK_I,
  input wire logic LINK_WR_I,
  input wire dbrk_pkg::dbrk_byte_t LINK_ADDR_I,
  input wire dbrk_pkg::dbrk_byte_t LINK_DATA_I,
  input wire logic DBG_CLK_PIN_I,
  input wire logic DBG_DATA_PIN_I,
  input wire dbrk_pkg::dbrk_addr_t CPU_ADDR_I,
  input wire dbrk_pkg::dbrk_byte_t CPU_UPPER_ADDRESS_BASE_I,
  input wire logic CPU_WIDE_I,
  input wire logic CPU_FIRST_I,
  input wire logic CPU_FETCH_I,
  input wire logic CPU_END_I,
  output logic BREAK_O,
  output logic RESET_REQ_O,
  output logic WAKE_O
);
  import dbrk_pkg::*;

  // Link domain: hold the write and flag it by a toggle.
  logic lk_tgl_reg;
  dbrk_byte_t lk_addr_reg;
  dbrk_byte_t lk_data_reg;
  always_ff @(posedge LINK_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      lk_tgl_reg <= 1'b0;
      lk_addr_reg <= 8'h00;
      lk_data_reg <= 8'h00;
    end else if (LINK_WR_I) begin
      lk_tgl_reg <= ~lk_tgl_reg;
      lk_addr_reg <= LINK_ADDR_I;
      lk_data_reg <= LINK_DATA_I;
    end
  end

  // Toggle synchroniser; the held bytes are stable when the edge is seen.
  logic tg1_reg;
  logic tg2_reg;
  logic tg3_reg;
  logic ck1_reg;
  logic ck2_reg;
  logic da1_reg;
  logic da2_reg;
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tg1_reg <= 1'b0;
      tg2_reg <= 1'b0;
      tg3_reg <= 1'b0;
      ck1_reg <= 1'b0;
      ck2_reg <= 1'b0;
      da1_reg <= 1'b1;
      da2_reg <= 1'b1;
    end else if (CE_I) begin
      tg1_reg <= lk_tgl_reg;
      tg2_reg <= tg1_reg;
      tg3_reg <= tg2_reg;
      ck1_reg <= DBG_CLK_PIN_I;
      ck2_reg <= ck1_reg;
      da1_reg <= DBG_DATA_PIN_I;
      da2_reg <= da1_reg;
    end
  end

  wire logic wr_stb;
  wire logic wr_ch;
  wire logic wr_ctl;
  wire logic wr_mst;
  assign wr_stb = CE_I & (tg2_reg ^ tg3_reg);
  assign wr_ch = wr_stb & (lk_addr_reg <= `DBRK_ADDR_CH_LAST)
    & (lk_addr_reg[1:0] != 2'h3);
  assign wr_ctl = wr_stb & (lk_addr_reg == `DBRK_BRK_CTL_OFS);
  assign wr_mst = wr_stb & (lk_addr_reg == `DBRK_MASTER_CTL_OFS);

  // Match address storage, one flop word per channel.
  dbrk_addr_t ch_reg [4];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      wire logic sel;
      assign sel = wr_ch & (lk_addr_reg[3:2] == 2'(gi));
      // RQ14 byte-wise write.
      always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
          ch_reg[gi] <= 24'h000000;
        end else if (sel) begin
          case (lk_addr_reg[1:0])
            2'h0: ch_reg[gi][7:0] <= lk_data_reg;
            2'h1: ch_reg[gi][15:8] <= lk_data_reg;
            default: ch_reg[gi][23:16] <= lk_data_reg;
          endcase
        end
      end
    end
  endgenerate

  // Control register bits.
  logic next_reg;
  logic next_next;
  logic [3:0] en_reg;
  logic ign1_reg;
  logic ign0_reg;
  logic step_reg;
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      en_reg <= 4'h0;
      ign1_reg <= 1'b0;
      ign0_reg <= 1'b0;
      step_reg <= 1'b0;
    end else if (wr_ctl) begin
      // RQ6 channel enables.
      en_reg <= lk_data_reg[`DBRK_BIT_EN_LO+3:`DBRK_BIT_EN_LO];
      ign1_reg <= lk_data_reg[`DBRK_BIT_IGN1];
      ign0_reg <= lk_data_reg[`DBRK_BIT_IGN0];
      // RQ11 single-step enable.
      step_reg <= lk_data_reg[`DBRK_BIT_STEP];
    end
  end

  // RQ13 compared address.
  wire dbrk_addr_t cmp_addr;
  assign cmp_addr = CPU_WIDE_I ? CPU_ADDR_I
    : {CPU_UPPER_ADDRESS_BASE_I, CPU_ADDR_I[15:0]};

  wire logic [3:0] ign;
  wire logic [3:0] hit;
  // RQ15 no page mode on channels 2 and 3.
  assign ign = {2'b00, ign1_reg, ign0_reg};
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      dbrk_match u_match (
        .addr_i(cmp_addr),
        .match_i(ch_reg[gi]),
        .enable_i(en_reg[gi]),
        .ign_low_i(ign[gi]),
        .hit_o(hit[gi])
      );
    end
  endgenerate

  // Strap capture on the third enabled edge after release, once the pins are synchronised.
  logic [1:0] strap_cnt_reg;
  wire logic strap_now;
  wire logic strap_brk;
  assign strap_now = CE_I & (strap_cnt_reg == 2'h2);
  // RQ3 strap decode.
  assign strap_brk = strap_now & ck2_reg & ~da2_reg;
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      strap_cnt_reg <= 2'h0;
    end else if (CE_I && strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  // A match mid-instruction waits for the instruction's end.
  logic pend_reg;
  wire logic any_hit;
  wire logic hit_now;
  wire logic hit_late;
  wire logic step_brk;
  wire logic next_brk;
  wire logic hw_set;
  wire logic host_clr;
  assign any_hit = CPU_FETCH_I & (|hit);
  // RQ2 breaks only at a first opcode.
  assign hit_now = any_hit & CPU_FIRST_I;
  assign hit_late = CPU_END_I & (pend_reg | (any_hit & ~CPU_FIRST_I));
  // RQ11 break after each instruction.
  assign step_brk = step_reg & CPU_END_I;
  assign next_brk = next_reg & CPU_FIRST_I;
  // RQ4 match sets break-next.
  assign hw_set = hit_now | hit_late | strap_brk;
  assign host_clr = wr_ctl & ~lk_data_reg[`DBRK_BIT_NEXT];

  // Hardware set wins over a host clear in the same cycle.
  always_comb begin
    next_next = next_reg;
    // RQ1 host clear.
    if (host_clr) begin
      next_next = 1'b0;
    end
    // RQ5 forced break by write.
    if (wr_ctl && lk_data_reg[`DBRK_BIT_NEXT]) begin
      next_next = 1'b1;
    end
    if (hw_set) begin
      next_next = 1'b1;
    end
  end

  logic brk_reg;
  logic brk_next;
  always_comb begin
    brk_next = brk_reg;
    // RQ1 release on clear.
    if (host_clr) begin
      brk_next = 1'b0;
    end
    if (hw_set || next_brk || step_brk) begin
      brk_next = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      next_reg <= 1'b0;
      brk_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else if (CE_I) begin
      next_reg <= next_next;
      brk_reg <= brk_next;
      pend_reg <= (pend_reg | (any_hit & ~CPU_FIRST_I)) & ~CPU_END_I;
    end
  end
  assign BREAK_O = brk_reg;

  // RQ12 master control: reset pulse and wake.
  dbrk_mstate_t mst_reg;
  dbrk_mstate_t mst_next;
  logic [7:0] rcnt_reg;
  logic wake_reg;
  logic rreq_reg;
  always_comb begin
    case (mst_reg)
      DBRK_RUN: mst_next = (wr_mst && lk_data_reg[`DBRK_BIT_MRESET])
        ? DBRK_RST : DBRK_RUN;
      DBRK_RST: mst_next = (rcnt_reg == 8'h01) ? DBRK_END : DBRK_RST;
      DBRK_END: mst_next = DBRK_RUN;
      default: mst_next = DBRK_RUN;
    endcase
  end
  always_ff @(posedge MCLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mst_reg <= DBRK_RUN;
      rcnt_reg <= 8'h00;
      wake_reg <= 1'b0;
      rreq_reg <= 1'b0;
    end else if (CE_I) begin
      mst_reg <= mst_next;
      rcnt_reg <= (mst_next == DBRK_RST && mst_reg == DBRK_RUN)
        ? 8'(`DBRK_RESET_CYC) : rcnt_reg - {7'h00, |rcnt_reg};
      wake_reg <= wr_mst & lk_data_reg[`DBRK_BIT_MWAKE];
      rreq_reg <= (mst_next == DBRK_RST);
    end
  end
  // Registered so the reset line never glitches on a state change.
  assign RESET_REQ_O = rreq_reg;
  assign WAKE_O = wake_reg;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  property p_release;
    host_clr && !hw_set && !next_brk && !step_brk
      |=> !BREAK_O && !next_reg;
  endproperty
  a_release: assert property (p_release) else $error("no release"); // RQ1

  property p_next_first;
    next_reg && CPU_FIRST_I && CE_I && !host_clr |=> BREAK_O;
  endproperty
  a_next_first: assert property (p_next_first) else $error("no break"); // RQ2

  property p_mid_wait;
    any_hit && !CPU_FIRST_I && !CPU_END_I && !next_reg && !step_reg
      && !BREAK_O && CE_I ##1 !CPU_END_I && !strap_now && !hit_now
      && !next_brk |=> !BREAK_O;
  endproperty
  a_mid_wait: assert property (p_mid_wait) else $error("mid break"); // RQ2

  property p_strap;
    strap_brk |=> next_reg && BREAK_O;
  endproperty
  a_strap: assert property (p_strap) else $error("strap lost"); // RQ3

  property p_hit_sets;
    hit_now && CE_I |=> next_reg ##0 BREAK_O;
  endproperty
  a_hit_sets: assert property (p_hit_sets) else $error("hit lost"); // RQ4

  property p_force;
    wr_ctl && lk_data_reg[`DBRK_BIT_NEXT] |=> next_reg;
  endproperty
  a_force: assert property (p_force) else $error("no force"); // RQ5

  property p_en_gate;
    !en_reg[1] |-> !hit[1];
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("gated hit"); // RQ6

  property p_page1;
    en_reg[1] && ign1_reg && cmp_addr[23:8] == ch_reg[1][23:8] |-> hit[1];
  endproperty
  a_page1: assert property (p_page1) else $error("page miss"); // RQ7

  property p_page0;
    en_reg[0] && ign0_reg && cmp_addr[23:8] == ch_reg[0][23:8] |-> hit[0];
  endproperty
  a_page0: assert property (p_page0) else $error("page0 miss"); // RQ9

  property p_full0;
    !ign0_reg && hit[0] |-> cmp_addr == ch_reg[0];
  endproperty
  a_full0: assert property (p_full0) else $error("full miss"); // RQ10

  property p_full3;
    hit[3] |-> cmp_addr == ch_reg[3];
  endproperty
  a_full3: assert property (p_full3) else $error("ch3 page"); // RQ15

  property p_step;
    step_reg && CPU_END_I && CE_I |=> BREAK_O;
  endproperty
  a_step: assert property (p_step) else $error("no step"); // RQ11

  property p_legacy;
    !CPU_WIDE_I |-> cmp_addr[23:16] == CPU_UPPER_ADDRESS_BASE_I;
  endproperty
  a_legacy: assert property (p_legacy) else $error("bad base"); // RQ13

  property p_mreset;
    wr_mst && lk_data_reg[`DBRK_BIT_MRESET] && mst_reg == DBRK_RUN
      && CE_I ##1 CE_I [*8] |-> RESET_REQ_O [*8];
  endproperty
  a_mreset: assert property (p_mreset) else $error("short reset"); // RQ12

  c_hit: cover property (hit_now ##1 BREAK_O);
  c_step: cover property (step_brk ##[1:20] host_clr);
  c_page: cover property (hit[1] && ign1_reg);
  c_reset: cover property (mst_reg == DBRK_END);
endmodule

/* File: rtl/dbrk_regs.svh */
// Offsets, fields, reset values and timing counts of the breakpoint block.
// Summary of operation
// RQ1: Clearing the break-next bit disables next-instruction breaks and releases a held break.
// RQ2: With break-next set the CPU halts on the next instruction, only at a first opcode byte.
// RQ3: Debug clock pin high and debug data pin low at reset end set break-next.
// RQ4: A break caused by an address match sets break-next automatically.
// RQ5: Writing 1 to break-next forces a break without any address match.
// RQ6: Control bits 6 to 3 enable match channels 3 to 0.
// RQ7: With bit 2 set, channel 1 matches on address bits 23:8 only.
// RQ8: With bit 2 clear, channel 1 matches on all 24 address bits.
// RQ9: With bit 1 set, channel 0 matches on address bits 23:8 only.
// RQ10: With bit 1 clear, channel 0 matches on all 24 address bits.
// RQ11: Control bit 0 enables single-step, a break after each instruction.
// RQ12: A master control register lets the host reset the device and wake the CPU.
// RQ13: In legacy mode the address is the base byte joined to bits 15:0, else bits 23:0.
// RQ14: Each channel holds a 24-bit address written as upper, high and low bytes.
// RQ15: Channels 2 and 3 always compare the full 24-bit address.
`ifndef DBRK_REGS_SVH
`define DBRK_REGS_SVH
`define DBRK_ADDR_CH_LAST 8'h0E
`define DBRK_BRK_CTL_OFS 8'h10
`define DBRK_MASTER_CTL_OFS 8'h11
`define DBRK_BRK_CTL_RST 8'h00
`define DBRK_BIT_NEXT 7
`define DBRK_BIT_EN_LO 3
`define DBRK_BIT_IGN1 2
`define DBRK_BIT_IGN0 1
`define DBRK_BIT_STEP 0
`define DBRK_BIT_MRESET 7
`define DBRK_BIT_MWAKE 6
`define DBRK_MCLK_NS 25
`define DBRK_RESET_NS 400
`define DBRK_RESET_CYC (`DBRK_RESET_NS / `DBRK_MCLK_NS)
`endif

/* File: rtl/dbrk_pkg.sv */
// Types shared by the breakpoint block.
package dbrk_pkg;
  typedef logic [23:0] dbrk_addr_t;
  typedef logic [7:0] dbrk_byte_t;
  typedef enum logic [1:0] {
    DBRK_RUN = 2'b00,
    DBRK_RST = 2'b01,
    DBRK_END = 2'b11
  } dbrk_mstate_t;
endpackage

/* File: rtl/dbrk_match.sv */
// One address match channel with optional page-granular compare.
module dbrk_match (
  input wire dbrk_pkg::dbrk_addr_t addr_i,
  input wire dbrk_pkg::dbrk_addr_t match_i,
  input wire logic enable_i,
  input wire logic ign_low_i,
  output logic hit_o
);
  import dbrk_pkg::*;
  wire logic page_eq;
  wire logic low_eq;
  assign page_eq = (addr_i[23:8] == match_i[23:8]);
  // RQ7 RQ9 page compare.
  assign low_eq = ign_low_i | (addr_i[7:0] == match_i[7:0]);
  // RQ8 RQ10 full compare.
  assign hit_o = enable_i & page_eq & low_eq;
endmodule

/* File: dv/dbrk_host_model.sv */
// Debug host model that drives the write side of the serial debug link.
module dbrk_host_model (
  output logic link_clk_o,
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    link_clk_o = 1'h0;
    wr_o = 1'h0;
    addr_o = 8'h00;
    data_o = 8'h00;
  end

  // The link clock runs only inside frames, so idle gaps show no edges.
  task automatic tick(input int n);
    repeat (n) begin
      #80 link_clk_o = 1'h1;
      #80 link_clk_o = 1'h0;
    end
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    #7;
    wr_o = 1'h1;
    addr_o = a;
    data_o = d;
    tick(1);
    wr_o = 1'h0;
    // Released lines flip so a stale byte can never pass for a live one.
    addr_o = ~a;
    data_o = ~d;
    // Idle cycles give the crossing time before the next byte.
    tick(2);
  endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the breakpoint control block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dbrk_pkg::*;

  logic mclk, rst, ce, dclk, ddat, wide, first, fetch, cend;
  logic lclk, lwr, brk, rreq, wake;
  dbrk_byte_t laddr, ldata, upper_address_base;
  dbrk_addr_t caddr, a;
  int n_mismatch = 0;
  int total_checks = 0;
  int rr_cnt = 0;
  int wk_cnt = 0;
  dbrk_addr_t pg_a [5] = '{24'hA05C77, 24'hA05C77, 24'hA15C01,
                           24'hA15C01, 24'hA25C00};
  logic [7:0] pg_c [5] = '{8'h0A, 8'h08, 8'h14, 8'h10, 8'h26};
  logic pg_e [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};

  dbrk_host_model host (.link_clk_o(lclk), .wr_o(lwr), .addr_o(laddr),
    .data_o(ldata));
  dbrk_top uut (.MCLK_I(mclk), .RESET_I(rst), .CE_I(ce), .LINK_CLK_I(lclk),
    .LINK_WR_I(lwr), .LINK_ADDR_I(laddr), .LINK_DATA_I(ldata),
    .DBG_CLK_PIN_I(dclk), .DBG_DATA_PIN_I(ddat), .CPU_ADDR_I(caddr),
    .CPU_UPPER_ADDRESS_BASE_I(upper_address_base),
    .CPU_WIDE_I(wide), .CPU_FIRST_I(first),
    .CPU_FETCH_I(fetch), .CPU_END_I(cend), .BREAK_O(brk),
    .RESET_REQ_O(rreq), .WAKE_O(wake));

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // Counted on the falling edge, where the registered outputs are settled.
  always @(negedge mclk) begin
    if (rreq === 1'h1)
      rr_cnt++;
    if (wake === 1'h1)
      wk_cnt++;
  end

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    host.write_reg(ad, d);
    repeat (4) @(negedge mclk);
  endtask

  task automatic do_fetch(input dbrk_addr_t ad, input logic f);
    @(negedge mclk);
    caddr = ad;
    fetch = 1'h1;
    first = f;
    @(negedge mclk);
    fetch = 1'h0;
    first = 1'h0;
    caddr = ~ad;
  endtask

  task automatic pulse_end();
    @(negedge mclk);
    cend = 1'h1;
    @(negedge mclk);
    cend = 1'h0;
  endtask

  task automatic expect_brk(input string name, input logic e);
    repeat (2) @(negedge mclk);
    check(name, {7'h00, e}, {7'h00, brk});
  endtask

  task automatic do_reset(input logic strap);
    @(negedge mclk);
    rst = 1'h1;
    dclk = strap;
    ddat = ~strap;
    repeat (6) @(negedge mclk);
    host.tick(1);
    @(negedge mclk);
    rst = 1'h0;
    repeat (5) @(negedge mclk);
    dclk = 1'h0;
    ddat = 1'h1;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    rst = 1'h1;
    ce = 1'h1;
    dclk = 1'h1;
    ddat = 1'h0;
    wide = 1'h1;
    first = 1'h0;
    fetch = 1'h0;
    cend = 1'h0;
    upper_address_base = 8'h00;
    caddr = 24'h000000;
    do_reset(1'h1);
    do_fetch(24'h000100, 1'h1);
    expect_brk("strap", 1'h1);
    wr(8'h10, 8'h00);
    expect_brk("release", 1'h0);
    wr(8'h10, 8'h80);
    expect_brk("force_wait", 1'h0);
    do_fetch(24'h000101, 1'h0);
    expect_brk("force_mid", 1'h0);
    do_fetch(24'h000102, 1'h1);
    expect_brk("force_first", 1'h1);
    wr(8'h10, 8'h00);
    for (int c = 0; c < 4; c++) begin
      a = {8'hA0 + c[7:0], 8'h5C, 8'h30 + c[7:0]};
      for (int b = 0; b < 3; b++)
        wr(8'(4 * c + b), a[8 * b +: 8]);
      wr(8'h10, 8'h08 << c);
      do_fetch(a ^ 24'h000001, 1'h1);
      expect_brk("chan_near", 1'h0);
      do_fetch(a, 1'h1);
      expect_brk("chan_hit", 1'h1);
      do_fetch(24'h000000, 1'h1);
      expect_brk("chan_hold", 1'h1);
      wr(8'h10, 8'h00);
      expect_brk("chan_rel", 1'h0);
      wr(8'h10, 8'h78 & ~(8'h08 << c));
      do_fetch(a, 1'h1);
      expect_brk("chan_off", 1'h0);
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, pg_c[i]);
      do_fetch(pg_a[i], 1'h1);
      expect_brk("page", pg_e[i]);
      wr(8'h10, 8'h00);
    end
    wr(8'h10, 8'h08);
    wide = 1'h0;
    upper_address_base = 8'hA0;
    do_fetch(24'hFF5C30, 1'h1);
    expect_brk("legacy", 1'h1);
    wide = 1'h1;
    wr(8'h10, 8'h08);
    wr(8'h10, 8'h08);
    do_fetch(24'hA05C30, 1'h0);
    expect_brk("wait_end", 1'h0);
    wr(8'h10, 8'h00);
    wr(8'h10, 8'h08);
    do_fetch(24'hA05C30, 1'h0);
    pulse_end();
    expect_brk("at_end", 1'h1);
    wr(8'h10, 8'h01);
    pulse_end();
    expect_brk("step", 1'h1);
    wr(8'h10, 8'h00);
    expect_brk("step_off", 1'h0);
    pulse_end();
    expect_brk("step_off_end", 1'h0);
    wr(8'h10, 8'h08);
    ce = 1'h0;
    do_fetch(24'hA05C30, 1'h1);
    expect_brk("ce_hold", 1'h0);
    ce = 1'h1;
    do_fetch(24'hA05C30, 1'h1);
    expect_brk("ce_run", 1'h1);
    wr(8'h10, 8'h00);
    rr_cnt = 0;
    wr(8'h11, 8'h80);
    repeat (30) @(negedge mclk);
    check("reset_len", 8'h10, rr_cnt[7:0]);
    wk_cnt = 0;
    wr(8'h11, 8'h40);
    repeat (4) @(negedge mclk);
    check("wake", 8'h01, wk_cnt[7:0]);
    do_reset(1'h0);
    do_fetch(24'h000100, 1'h1);
    expect_brk("no_strap", 1'h0);
    summarize();
  end
endmodule
